/* pkg/sfm_consts.vh */
`ifndef SFM_CONSTS_VH
`define SFM_CONSTS_VH

// ============================================================
// Array geometry
`define SFM_DATA_W      12
`define SFM_ROWS        512
`define SFM_COLS        512

// ============================================================
// Old-field window, counted in write-clock edges
`define SFM_OLD_WINDOW  70
// Commit lag kept a little beyond the window
`define SFM_DLY_DEPTH   (`SFM_OLD_WINDOW + 2)

// ============================================================
// Reset values
`define SFM_PTR_RST     0
`define SFM_DOUT_RST    12'h000

`endif

/* rtl/sfm_mem.v */
`timescale 1ns/1ns
// ============================================================
// Simple dual-port memory, registered read data
module sfm_mem #(
  parameter DW    = 12,
  parameter AW    = 18,
  parameter DEPTH = 262144
) (
  // Clock and reset
  input  wire          clk_sys,
  input  wire          reset_n,
  // Write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  // Read port
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);

  reg [DW-1:0] store [0:DEPTH-1];

  always @(posedge clk_sys) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= {DW{1'b0}};
    end else begin
      rd_data <= store[rd_addr];
    end
  end

endmodule

/* rtl/sfm_field_memory.v */
// Summary of operation
// - Store 12-bit words, 512 rows by 512 columns
// - Write clear zeroes write pointer, ignores gate, mask
// - Write timing lags read timing one clock
// - Gate high: capture word, advance write pointer
// - Gate low: no capture, write pointer holds
// - Mask low blocks storing, pointer still advances
// - Read clear zeroes read pointer, ignores gate, drive
// - Read gate high shifts next word, advances pointer
// - Outputs driven only with drive high; pointer advances
// - First word available right after pointer clear
// - Storage static; clocks may stop indefinitely
// - Read clear within 70 writes gives old field
`timescale 1ns/1ns
`include "sfm_consts.vh"

module sfm_field_memory #(
  parameter DW        = `SFM_DATA_W,
  parameter ROWS      = `SFM_ROWS,
  parameter COLS      = `SFM_COLS,
  parameter DLY_DEPTH = `SFM_DLY_DEPTH
) (
  // Clock and reset
  input  wire          clk_sys,
  input  wire          reset_n,
  // Write port
  input  wire          wr_shift_clock,
  input  wire          wr_pointer_clear,
  input  wire          wr_advance_gate,
  input  wire          wr_cell_mask,
  input  wire [DW-1:0] wr_data_in,
  // Read port
  input  wire          rd_shift_clock,
  input  wire          rd_pointer_clear,
  input  wire          rd_advance_gate,
  input  wire          rd_output_drive,
  output reg  [DW-1:0] rd_data_out,
  output reg           rd_data_oe
);

  // ============================================================
  // Sizes
  function integer clog2_f;
    input integer val;
    integer v;
    begin
      v = val - 1;
      clog2_f = 0;
      while (v > 0) begin
        clog2_f = clog2_f + 1;
        v = v >> 1;
      end
    end
  endfunction

  localparam WORDS = ROWS * COLS;
  localparam AW    = clog2_f(WORDS);
  localparam SW    = clog2_f(DLY_DEPTH);
  localparam EW    = 1 + AW + DW;

  // Wrapping increment shared by both pointers
  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      if (p == WORDS[AW-1:0] - 1'b1) begin
        ptr_inc = {AW{1'b0}};
      end else begin
        ptr_inc = p + 1'b1;
      end
    end
  endfunction

  // ============================================================
  // Shift clock edge detection (pins are synchronous to clk_sys)
  // Rising edge of a sampled shift clock
  function rise_f;
    input now;
    input prev;
    begin
      rise_f = now & ~prev;
    end
  endfunction

  reg  wr_clk_prev_reg;
  reg  rd_clk_prev_reg;
  wire wr_edge = rise_f(wr_shift_clock, wr_clk_prev_reg);
  wire rd_edge = rise_f(rd_shift_clock, rd_clk_prev_reg);

  // Detectors start high: a clock already high at release is no edge
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_clk_prev_reg <= 1'b1;
    end else begin
      wr_clk_prev_reg <= wr_shift_clock;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_clk_prev_reg <= 1'b1;
    end else begin
      rd_clk_prev_reg <= rd_shift_clock;
    end
  end

  // ============================================================
  // Write side
  // Each write-clock edge enters one slot of a commit delay line;
  // the slot leaving it is written to the array. The lag keeps
  // the old field intact for a read clear that trails a write clear.
  reg  [AW-1:0] wr_ptr_reg;
  reg  [AW-1:0] wr_ptr_next;
  reg  [SW-1:0] slot_reg;
  reg  [SW:0]   fill_reg;
  reg           commit_we_reg;
  reg  [AW-1:0] commit_addr_reg;
  reg  [DW-1:0] commit_data_reg;
  reg  [EW-1:0] entry_next;
  reg           entry_live;
  wire [EW-1:0] dly_rdata;
  wire          fill_full = (fill_reg == DLY_DEPTH[SW:0]);

  always @* begin
    wr_ptr_next = wr_ptr_reg;
    entry_live  = 1'b0;
    if (wr_pointer_clear) begin
      wr_ptr_next = {AW{1'b0}};
    end else if (wr_advance_gate) begin
      entry_live  = wr_cell_mask;
      wr_ptr_next = ptr_inc(wr_ptr_reg);
    end
    entry_next = {entry_live, wr_ptr_reg, wr_data_in};
  end

  // Next slot of the commit line, wrapping after the last one
  function [SW-1:0] slot_inc;
    input [SW-1:0] s;
    begin
      if (s == DLY_DEPTH[SW-1:0] - 1'b1) begin
        slot_inc = {SW{1'b0}};
      end else begin
        slot_inc = s + 1'b1;
      end
    end
  endfunction

  // Write pointer moves only on write edges
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= {AW{1'b0}};
    end else if (wr_edge) begin
      wr_ptr_reg <= wr_ptr_next;
    end
  end

  // Slot index of the commit line
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slot_reg <= {SW{1'b0}};
    end else if (wr_edge) begin
      slot_reg <= slot_inc(slot_reg);
    end
  end

  // Fill count: slots read before the line has filled hold no word
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fill_reg <= {(SW+1){1'b0}};
    end else if (wr_edge && !fill_full) begin
      fill_reg <= fill_reg + 1'b1;
    end
  end

  // Oldest slot moves into the array one clk_sys cycle after the edge; a clear
  // edge also advances it, retiring one pending word
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      commit_we_reg <= 1'b0;
    end else begin
      commit_we_reg <= wr_edge & fill_full & dly_rdata[EW-1];
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      commit_addr_reg <= {AW{1'b0}};
      commit_data_reg <= {DW{1'b0}};
    end else if (wr_edge) begin
      commit_addr_reg <= dly_rdata[DW +: AW];
      commit_data_reg <= dly_rdata[DW-1:0];
    end
  end

  // Slot memory holds pending words; its read data is prefetched
  // for the current slot, valid before the next edge can arrive
  sfm_mem #(
    .DW    (EW),
    .AW    (SW),
    .DEPTH (DLY_DEPTH)
  ) u_commit_line (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .wr_en   (wr_edge),
    .wr_addr (slot_reg),
    .wr_data (entry_next),
    .rd_addr (slot_reg),
    .rd_data (dly_rdata)
  );

  // ============================================================
  // Field array
  // Static storage with one committing writer: nothing to refresh,
  // so either shift clock may halt for any time
  reg  [AW-1:0] rd_ptr_reg;
  reg  [AW-1:0] rd_ptr_next;
  wire [DW-1:0] array_rdata;

  sfm_mem #(
    .DW    (DW),
    .AW    (AW),
    .DEPTH (WORDS)
  ) u_field_array (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .wr_en   (commit_we_reg),
    .wr_addr (commit_addr_reg),
    .wr_data (commit_data_reg),
    .rd_addr (rd_ptr_reg),
    .rd_data (array_rdata)
  );

  // ============================================================
  // Read side
  // Word at the read pointer is fetched continuously, so after a
  // clear word zero is ready by the next read edge
  // A halted write clock leaves the last words of the commit line
  // pending; the controller's closing clear plus further edges
  // retire them. Reads of a word still pending return the old one.
  always @* begin
    rd_ptr_next = rd_ptr_reg;
    if (rd_pointer_clear) begin
      rd_ptr_next = {AW{1'b0}};
    end else if (rd_advance_gate) begin
      rd_ptr_next = ptr_inc(rd_ptr_reg);
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_ptr_reg <= {AW{1'b0}};
    end else if (rd_edge) begin
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Data register changes only on a moving, non-clear read edge
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_out <= `SFM_DOUT_RST;
    end else if (rd_edge && !rd_pointer_clear && rd_advance_gate) begin
      rd_data_out <= array_rdata;
    end
  end

  // Drive level follows every non-clear edge, gate or not
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_oe <= 1'b0;
    end else if (rd_edge && !rd_pointer_clear) begin
      rd_data_oe <= rd_output_drive;
    end
  end

endmodule

/* bench/sfm_chk.sv */
`timescale 1ns/1ns
module sfm_chk #(parameter DW = 12) (
  // Clock and reset
  input wire          clk_sys,
  input wire          reset_n,
  // Write port
  input wire          wr_shift_clock,
  input wire          wr_pointer_clear,
  input wire          wr_advance_gate,
  input wire          wr_cell_mask,
  input wire [DW-1:0] wr_data_in,
  // Read port
  input wire          rd_shift_clock,
  input wire          rd_pointer_clear,
  input wire          rd_advance_gate,
  input wire          rd_output_drive,
  input wire [DW-1:0] rd_data_out,
  input wire          rd_data_oe
);
  reg  rprev_reg;
  wire e  = rd_shift_clock & ~rprev_reg;
  wire ec = e & rd_pointer_clear;
  wire en = e & ~rd_pointer_clear;
  // Detector starts from high so a clock already high at release is no edge
  always @(posedge clk_sys or negedge reset_n)
    if (!reset_n) rprev_reg <= 1'b1;
    else rprev_reg <= rd_shift_clock;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ====================
  // Read port
  property p_clr; ec |=> $stable({rd_data_out, rd_data_oe}); endproperty
  a_clr: assert property (p_clr) else $error("clear moved outputs");
  property p_hold; en & ~rd_advance_gate |=> $stable(rd_data_out); endproperty
  a_hold: assert property (p_hold) else $error("gate low moved data");
  property p_oe; en & rd_advance_gate |=> rd_data_oe == $past(rd_output_drive); endproperty
  a_oe: assert property (p_oe) else $error("enable wrong");
  property p_oeg; en & ~rd_advance_gate |=> rd_data_oe == $past(rd_output_drive); endproperty
  a_oeg: assert property (p_oeg) else $error("enable wrong, gate low");
  property p_idle; !e |=> $stable({rd_data_out, rd_data_oe}); endproperty
  a_idle: assert property (p_idle) else $error("outputs moved idle");
  property p_dchg; $changed(rd_data_out) |-> $past(en & rd_advance_gate); endproperty
  a_dchg: assert property (p_dchg) else $error("data moved off edge");
  property p_ochg; $changed(rd_data_oe) |-> $past(en); endproperty
  a_ochg: assert property (p_ochg) else $error("enable moved off edge");
  property p_rst; $rose(reset_n) |-> rd_data_out == 12'h000 && !rd_data_oe; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule
bind sfm_field_memory sfm_chk #(.DW(DW)) sfm_chk_inst (
  .clk_sys, .reset_n, .wr_shift_clock, .wr_pointer_clear, .wr_advance_gate,
  .wr_cell_mask, .wr_data_in, .rd_shift_clock, .rd_pointer_clear,
  .rd_advance_gate, .rd_output_drive, .rd_data_out, .rd_data_oe);

/* bench/sfm_ctl_model.sv */
`timescale 1ns/1ns
module sfm_ctl_model (
  // Clock
  input  wire        clk_sys,
  // Write side
  output reg         wr_shift_clock,
  output reg         wr_pointer_clear,
  output reg         wr_advance_gate,
  output reg         wr_cell_mask,
  output reg  [11:0] wr_data_in,
  // Read side
  output reg         rd_shift_clock,
  output reg         rd_pointer_clear,
  output reg         rd_advance_gate,
  output reg         rd_output_drive
);
  initial {wr_shift_clock, wr_pointer_clear, wr_advance_gate, wr_cell_mask} = 4'h0;
  initial wr_data_in = 12'h000;
  initial {rd_shift_clock, rd_pointer_clear, rd_advance_gate, rd_output_drive} = 4'h0;
  // ====================
  // Edges take two cycles; clocks stand high between; gate-low data shows inverse
  task wr_edge(input c, input g, input m, input [11:0] d);
    begin
      @(posedge clk_sys) wr_shift_clock <= 1'b0;
      {wr_pointer_clear, wr_advance_gate, wr_cell_mask} <= {c, g, m};
      wr_data_in <= g ? d : ~d;
      @(posedge clk_sys) wr_shift_clock <= 1'b1;
    end
  endtask
  task rd_edge(input c, input g, input v);
    begin
      @(posedge clk_sys) rd_shift_clock <= 1'b0;
      {rd_pointer_clear, rd_advance_gate, rd_output_drive} <= {c, g, v};
      @(posedge clk_sys) rd_shift_clock <= 1'b1;
    end
  endtask
endmodule

/* bench/serial_field_memory_fifo_tb.sv */
`timescale 1ns/1ns
module serial_field_memory_fifo_tb;
  reg         clk_sys = 1'b0;
  reg         reset_n = 1'b0;
  reg         rprev = 1'b1;
  reg         hit = 1'b0;
  reg  [11:0] mem [0:15];
  reg  [12:0] expq [$];
  reg  [31:0] r;
  integer     errors = 0;
  integer     n_compared = 0;
  integer     i;
  integer     p = 0;
  wire        wr_shift_clock, wr_pointer_clear, wr_advance_gate, wr_cell_mask;
  wire        rd_shift_clock, rd_pointer_clear, rd_advance_gate, rd_output_drive;
  wire        rd_data_oe;
  wire [11:0] wr_data_in, rd_data_out;
  always #2 clk_sys = ~clk_sys;
  sfm_ctl_model sfm_ctl_model_inst (.clk_sys, .wr_shift_clock, .wr_pointer_clear,
    .wr_advance_gate, .wr_cell_mask, .wr_data_in, .rd_shift_clock, .rd_pointer_clear,
    .rd_advance_gate, .rd_output_drive);
  sfm_field_memory #(.ROWS(4), .COLS(4), .DLY_DEPTH(4)) sfm_field_memory_inst (
    .clk_sys, .reset_n, .wr_shift_clock, .wr_pointer_clear, .wr_advance_gate,
    .wr_cell_mask, .wr_data_in, .rd_shift_clock, .rd_pointer_clear,
    .rd_advance_gate, .rd_output_drive, .rd_data_out, .rd_data_oe);
  task check(input [12:0] seen, input [12:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Write edge plus the model of pointer and array
  task wr(input c, input g, input m);
    reg [11:0] d;
    begin
      d = $urandom;
      sfm_ctl_model_inst.wr_edge(c, g, m, d);
      if (c) p = 0;
      else if (g) begin
        if (m) mem[p] = d;
        p = (p + 1) % 16;
      end
    end
  endtask
  // ====================
  // Result watcher: output is settled one cycle after a moving read edge
  always @(posedge clk_sys) begin
    if (hit) check({rd_data_oe, rd_data_out}, expq.pop_front());
    hit <= rd_shift_clock & ~rprev & ~rd_pointer_clear & rd_advance_gate;
    rprev <= rd_shift_clock;
  end
  initial begin
    i = $urandom(32'ha7c976ec);
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (i = 0; i < 80; i = i + 1) begin
      r = $urandom;
      wr(1'b0, 1'b1, 1'b1);
      sfm_ctl_model_inst.rd_edge(1'b0, 1'b0, r[0]);
    end
    $display("test init done");
    wr(1'b1, 1'b1, 1'b1);
    sfm_ctl_model_inst.rd_edge(1'b1, 1'b1, 1'b1);
    for (i = 0; i < 96; i = i + 1) begin
      r = $urandom;
      wr(1'b0, i % 7 != 3, r[13:12] != 2'b00);
    end
    // Flushing clear, then masked edges retire the commit line
    wr(1'b1, 1'b1, 1'b1);
    repeat (8) wr(1'b0, 1'b1, 1'b0);
    $display("test write done");
    sfm_ctl_model_inst.rd_edge(1'b1, 1'b0, 1'b0);
    p = 0;
    for (i = 0; i < 80; i = i + 1) begin
      r = $urandom;
      if (i % 9 != 4) begin
        expq.push_back({r[0], mem[p]});
        p = (p + 1) % 16;
      end
      sfm_ctl_model_inst.rd_edge(1'b0, i % 9 != 4, r[0]);
    end
    for (i = 0; i < 20 && expq.size() > 0; i = i + 1) @(posedge clk_sys);
    if (expq.size() > 0) errors = errors + 1;
    $display("test read done");
    give_verdict;
  end
endmodule
